// ===== rtl/uec_event_ctrl.sv
// USB event enable gating, control register and shared interrupt
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
// Functional notes
// - Event enable register keeps only bits 7:0; upper bits read zero.
// - Bit 7 enables the stall handshake interrupt.
// - Bit 6 enables the attach detected interrupt.
// - Bit 4 enables the bus idle interrupt.
// - Bit 3 enables the token done flag.
// - Bit 2 enables the frame start flag.
// - Device mode: bit 0 enables the bus reset flag.
// - Host mode: bit 0 enables the unplug flag instead.
// - Errors reach the shared flag only while bit 1 is set.
// - Device mode: setup token sets hold bit until software clears it.
// - Host mode: control bit 5 reads one while a token executes.
// - Any toggle of host enable resets all host control logic.
module uec_event_ctrl #(
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire uec_pkg::uec_bus_req_t busReq,
  output logic [DATA_W-1:0] rdata,
  input wire uec_pkg::uec_usb_evt_t usbEvt,
  output logic usbIrq,
  output logic sharedIrqFlag,
  output logic [7:0] controlOut,
  output logic hostLogicReset,
  output logic resumeEop
);
  import uec_pkg::*;

  // Read mux and upper zero fill are built for one word width
  if (DATA_W != 32) begin : gen_width_check
    $error("DATA_W must be 32");
  end

  logic [7:0] eventEnable, next_eventEnable;
  logic [7:0] control, next_control;
  logic [7:0] status, next_status;
  logic [7:0] mask, next_mask;
  logic [DATA_W-1:0] next_rdata;
  logic usbIrqR, next_usbIrq;
  logic sharedR, next_shared;
  logic hostRst, next_hostRst;
  logic eop, next_eop;
  logic tokenBusy, next_tokenBusy;
  uec_host_state_t hostState, next_hostState;
  logic [7:0] gated;
  logic hostMode;
  logic ctlWrite;
  logic statusRead;
  logic hostToggle;

  function automatic logic hit(input uec_bus_req_t r, input logic [3:0] off);
    hit = (r.addr == off);
  endfunction

  assign hostMode = control[CTL_HOST_EN];
  // Decodes used by the checks; only statusRead also drives the logic
  assign ctlWrite = busReq.wr && hit(busReq, OFF_MODULE_CONTROL);
  assign statusRead = busReq.rd && hit(busReq, OFF_EVENT_STATUS);
  assign hostToggle = ctlWrite && (busReq.wdata[CTL_HOST_EN] != hostMode);

  always_comb begin
    gated[EV_STALL] = usbEvt.flags[EV_STALL] & eventEnable[EV_STALL];
    gated[EV_ATTACH] = usbEvt.flags[EV_ATTACH] & eventEnable[EV_ATTACH];
    gated[EV_RESUME] = usbEvt.flags[EV_RESUME] & eventEnable[EV_RESUME];
    gated[EV_IDLE] = usbEvt.flags[EV_IDLE] & eventEnable[EV_IDLE];
    gated[EV_TOKEN] = usbEvt.flags[EV_TOKEN] & eventEnable[EV_TOKEN];
    gated[EV_FRAME] = usbEvt.flags[EV_FRAME] & eventEnable[EV_FRAME];
    gated[EV_ERROR] = usbEvt.flags[EV_ERROR] & eventEnable[EV_ERROR];
    // Device bus reset, host unplug share bit 0
    gated[EV_RESET_UNPLUG] = usbEvt.flags[EV_RESET_UNPLUG] & eventEnable[EV_RESET_UNPLUG];
  end

  always_comb begin
    next_eventEnable = eventEnable;
    next_control = control;
    next_mask = mask;
    next_rdata = '0;
    if (busReq.wr) begin
      case (busReq.addr)
        OFF_EVENT_ENABLE: next_eventEnable = busReq.wdata[7:0];
        OFF_MODULE_CONTROL: begin
          next_control[CTL_BUS_RESET] = busReq.wdata[CTL_BUS_RESET];
          next_control[CTL_HOST_EN] = busReq.wdata[CTL_HOST_EN];
          next_control[CTL_RESUME] = busReq.wdata[CTL_RESUME];
          next_control[CTL_PINGPONG] = busReq.wdata[CTL_PINGPONG];
          next_control[CTL_ENABLE] = busReq.wdata[CTL_ENABLE];
          if (!hostMode) begin
            next_control[CTL_HOLD_BUSY] = busReq.wdata[CTL_HOLD_BUSY];
          end
        end
        OFF_STATUS_MASK: next_mask = busReq.wdata[7:0];
        default: ;
      endcase
    end
    next_control[CTL_LINE_J] = usbEvt.lineJ;
    next_control[CTL_LINE_SE0] = usbEvt.lineSe0;
    if (!hostMode && usbEvt.setupSeen) begin
      next_control[CTL_HOLD_BUSY] = 1'b1;
    end
    if (hostMode) begin
      next_control[CTL_HOLD_BUSY] = next_tokenBusy;
    end
    if (busReq.rd) begin
      case (busReq.addr)
        OFF_EVENT_ENABLE: next_rdata = {24'h00_0000, eventEnable};
        OFF_MODULE_CONTROL: next_rdata = {24'h00_0000, control};
        OFF_EVENT_STATUS: next_rdata = {24'h00_0000, status};
        OFF_STATUS_MASK: next_rdata = {24'h00_0000, mask};
        default: next_rdata = '0;
      endcase
    end
  end

  always_comb begin
    // Set wins over a read clear, so no event is lost
    next_status = status;
    if (statusRead) begin
      next_status = '0;
    end
    next_status = next_status | gated;
    next_shared = |gated;
    // Next mask too, so a mask write shows on the line at once
    next_usbIrq = |(next_status & next_mask);
  end

  always_comb begin
    next_hostState = hostState;
    next_tokenBusy = tokenBusy;
    next_hostRst = 1'b0;
    // End of packet when resume clears in host mode
    next_eop = hostMode && control[CTL_RESUME] && busReq.wr && hit(busReq, OFF_MODULE_CONTROL)
      && !busReq.wdata[CTL_RESUME];
    case (hostState)
      HST_IDLE: begin
        if (hostMode && usbEvt.tokenStart) begin
          next_hostState = HST_BUSY;
          next_tokenBusy = 1'b1;
        end
      end
      HST_BUSY: begin
        if (usbEvt.tokenEnd) begin
          next_hostState = HST_IDLE;
          next_tokenBusy = 1'b0;
        end
      end
      HST_RESET: next_hostState = HST_IDLE;
      default: next_hostState = HST_IDLE;
    endcase
    // Toggle of host enable resets host logic
    if (busReq.wr && hit(busReq, OFF_MODULE_CONTROL) && (busReq.wdata[CTL_HOST_EN] != hostMode)) begin
      next_hostState = HST_RESET;
      next_tokenBusy = 1'b0;
      next_hostRst = 1'b1;
      next_eop = 1'b0;
    end
  end

  // Software visible registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      eventEnable <= ENABLE_RESET;
      control <= CONTROL_RESET;
      mask <= MASK_RESET;
      rdata <= '0;
    end else begin
      eventEnable <= next_eventEnable;
      control <= next_control;
      mask <= next_mask;
      rdata <= next_rdata;
    end
  end

  // Sticky status and interrupt lines
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status <= '0;
      usbIrqR <= 1'b0;
      sharedR <= 1'b0;
    end else begin
      status <= next_status;
      usbIrqR <= next_usbIrq;
      sharedR <= next_shared;
    end
  end

  // Host token tracking
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hostRst <= 1'b0;
      eop <= 1'b0;
      tokenBusy <= 1'b0;
      hostState <= HST_IDLE;
    end else begin
      hostRst <= next_hostRst;
      eop <= next_eop;
      tokenBusy <= next_tokenBusy;
      hostState <= next_hostState;
    end
  end

  assign usbIrq = usbIrqR;
  assign sharedIrqFlag = sharedR;
  assign controlOut = control;
  assign hostLogicReset = hostRst;
  assign resumeEop = eop;

  a_upper_zero: assert property (@(posedge clk) disable iff (!reset_n)
    $past(busReq.rd) |-> rdata[31:8] == 24'h00_0000) else $error("upper bits not zero");
  a_stall_gate: assert property (@(posedge clk) disable iff (!reset_n)
    usbEvt.flags[EV_STALL] && eventEnable[EV_STALL] |=> sharedIrqFlag) else $error("stall not gated");
  a_attach_gate: assert property (@(posedge clk) disable iff (!reset_n)
    usbEvt.flags[EV_ATTACH] && eventEnable[EV_ATTACH] |=> sharedIrqFlag) else $error("attach not gated");
  a_resume_gate: assert property (@(posedge clk) disable iff (!reset_n)
    usbEvt.flags[EV_RESUME] && eventEnable[EV_RESUME] |=> sharedIrqFlag) else $error("resume not gated");
  a_idle_gate: assert property (@(posedge clk) disable iff (!reset_n)
    usbEvt.flags[EV_IDLE] && eventEnable[EV_IDLE] |=> sharedIrqFlag) else $error("idle not gated");
  a_token_gate: assert property (@(posedge clk) disable iff (!reset_n)
    usbEvt.flags[EV_TOKEN] && eventEnable[EV_TOKEN] |=> sharedIrqFlag) else $error("token not gated");
  a_frame_gate: assert property (@(posedge clk) disable iff (!reset_n)
    usbEvt.flags[EV_FRAME] && eventEnable[EV_FRAME] |=> sharedIrqFlag) else $error("frame not gated");
  a_reset_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !hostMode && usbEvt.flags[EV_RESET_UNPLUG] && eventEnable[EV_RESET_UNPLUG]
    |=> sharedIrqFlag) else $error("bus reset not gated");
  a_unplug_gate: assert property (@(posedge clk) disable iff (!reset_n)
    hostMode && usbEvt.flags[EV_RESET_UNPLUG] && eventEnable[EV_RESET_UNPLUG]
    |=> sharedIrqFlag) else $error("unplug not gated");
  a_error_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (usbEvt.flags & eventEnable) == 8'h00 |=> !sharedIrqFlag) else $error("flag without enable");
  a_setup_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !hostMode && usbEvt.setupSeen && !(busReq.wr && hit(busReq, OFF_MODULE_CONTROL))
    |=> controlOut[CTL_HOLD_BUSY]) else $error("setup did not hold");
  a_host_toggle: assert property (@(posedge clk) disable iff (!reset_n)
    busReq.wr && hit(busReq, OFF_MODULE_CONTROL) && busReq.wdata[CTL_HOST_EN] != hostMode
    |=> hostLogicReset && !tokenBusy) else $error("host toggle missed");
  a_busy_show: assert property (@(posedge clk) disable iff (!reset_n)
    hostMode && tokenBusy && !usbEvt.tokenEnd && !hostToggle
    |=> controlOut[CTL_HOLD_BUSY]) else $error("busy not shown");
  c_irq: cover property (@(posedge clk) disable iff (!reset_n) usbIrq);
  c_setup: cover property (@(posedge clk) disable iff (!reset_n) !hostMode && usbEvt.setupSeen);
  c_token: cover property (@(posedge clk) disable iff (!reset_n) hostState == HST_BUSY);
  c_toggle: cover property (@(posedge clk) disable iff (!reset_n) hostLogicReset);
  c_eop: cover property (@(posedge clk) disable iff (!reset_n) resumeEop);

  a_error_block: assert property (@(posedge clk) disable iff (!reset_n)
    !eventEnable[EV_ERROR] && !status[EV_ERROR] |=> !status[EV_ERROR]) else $error("error without enable");
  a_error_pass: assert property (@(posedge clk) disable iff (!reset_n)
    usbEvt.flags[EV_ERROR] && eventEnable[EV_ERROR] |=> status[EV_ERROR]) else $error("error not latched");
  a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
    usbIrq == |(status & mask)) else $error("irq level wrong");
  a_status_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    !statusRead
    |=> (status & $past(status)) == $past(status)) else $error("status bit lost");
  a_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
    statusRead && gated == 8'h00
    |=> status == 8'h00) else $error("status not cleared");
  a_status_read: assert property (@(posedge clk) disable iff (!reset_n)
    statusRead |=> rdata[7:0] == $past(status)) else $error("status read wrong");
  a_mask_write: assert property (@(posedge clk) disable iff (!reset_n)
    busReq.wr && hit(busReq, OFF_STATUS_MASK)
    |=> mask == $past(busReq.wdata[7:0])) else $error("mask write lost");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(busReq.rd) |-> rdata == '0) else $error("read data not idle");
  a_enable_write: assert property (@(posedge clk) disable iff (!reset_n)
    busReq.wr && hit(busReq, OFF_EVENT_ENABLE)
    |=> eventEnable == $past(busReq.wdata[7:0])) else $error("enable write lost");
  a_host_ro: assert property (@(posedge clk) disable iff (!reset_n)
    hostMode && ctlWrite && busReq.wdata[CTL_HOST_EN] && !tokenBusy && !usbEvt.tokenStart
    |=> !controlOut[CTL_HOLD_BUSY]) else $error("busy bit written");
  a_host_idle: assert property (@(posedge clk) disable iff (!reset_n)
    hostMode && !hostToggle && !tokenBusy && !usbEvt.tokenStart
    |=> !controlOut[CTL_HOLD_BUSY]) else $error("busy without token");
  a_idle_state: assert property (@(posedge clk) disable iff (!reset_n)
    !tokenBusy |-> hostState != HST_BUSY) else $error("busy state mismatch");
  a_reset_state: assert property (@(posedge clk) disable iff (!reset_n)
    hostLogicReset |-> hostState == HST_RESET) else $error("host reset state");
  a_device_nobusy: assert property (@(posedge clk) disable iff (!reset_n)
    !hostMode
    |-> hostState != HST_BUSY) else $error("busy in device mode");
  a_eop_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    hostMode && control[CTL_RESUME] && ctlWrite && !hostToggle && !busReq.wdata[CTL_RESUME]
    |=> resumeEop) else $error("end of packet missed");
  a_eop_single: assert property (@(posedge clk) disable iff (!reset_n)
    resumeEop |=> !resumeEop) else $error("end of packet too long");
endmodule

// ===== rtl/uec_pkg.sv
// Package for the USB event enable and control block
package uec_pkg;
  localparam int REG_AW = 4;
  localparam logic [3:0] OFF_EVENT_ENABLE = 4'h0;
  localparam logic [3:0] OFF_MODULE_CONTROL = 4'h4;
  localparam logic [3:0] OFF_EVENT_STATUS = 4'h8;
  localparam logic [3:0] OFF_STATUS_MASK = 4'hC;
  localparam int EV_STALL = 7;
  localparam int EV_ATTACH = 6;
  localparam int EV_RESUME = 5;
  localparam int EV_IDLE = 4;
  localparam int EV_TOKEN = 3;
  localparam int EV_FRAME = 2;
  localparam int EV_ERROR = 1;
  localparam int EV_RESET_UNPLUG = 0;
  localparam int CTL_LINE_J = 7;
  localparam int CTL_LINE_SE0 = 6;
  localparam int CTL_HOLD_BUSY = 5;
  localparam int CTL_BUS_RESET = 4;
  localparam int CTL_HOST_EN = 3;
  localparam int CTL_RESUME = 2;
  localparam int CTL_PINGPONG = 1;
  localparam int CTL_ENABLE = 0;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int HOST_RESET_CYCLES = 1;

  typedef struct packed {
    logic [REG_AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } uec_bus_req_t;

  typedef struct packed {
    logic [7:0] flags;
    logic setupSeen;
    logic tokenStart;
    logic tokenEnd;
    logic lineJ;
    logic lineSe0;
  } uec_usb_evt_t;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b001,
    HST_BUSY = 3'b010,
    HST_RESET = 3'b100
  } uec_host_state_t;
endpackage

// ===== test/uec_usb_far.sv
// USB side stand-in: raises event flags and token pulses
`timescale 1ns/1ns
module uec_usb_far (
  input wire logic clk,
  input wire logic [7:0] flagsIn,
  input wire logic [2:0] pulseIn,
  output uec_pkg::uec_usb_evt_t usbEvt
);
  import uec_pkg::*;
  always_ff @(posedge clk) begin
    usbEvt.flags <= flagsIn;
    {usbEvt.setupSeen, usbEvt.tokenStart, usbEvt.tokenEnd} <= pulseIn;
    // Idle bus rests in J
    usbEvt.lineJ <= 1'b1;
    usbEvt.lineSe0 <= 1'b0;
  end
endmodule

// ===== test/usb_event_enable_and_control_tb.sv
// Self-checking bench for the USB event enable and control block
`timescale 1ns/1ns
module usb_event_enable_and_control_tb;
  import uec_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  uec_bus_req_t busReq = '0;
  uec_usb_evt_t usbEvt;
  logic [31:0] rdata;
  logic [7:0] controlOut;
  logic [7:0] flagsIn = 8'h00;
  logic [2:0] pulseIn = 3'h0;
  logic usbIrq, sharedIrqFlag, hostLogicReset, resumeEop;
  int errTotal = 0;
  int checksDone = 0;
  int hostPulses = 0;
  int eopPulses = 0;
  always #2 clk = ~clk;
  uec_event_ctrl uec_event_ctrl_inst (.clk(clk), .reset_n(reset_n), .busReq(busReq), .rdata(rdata),
    .usbEvt(usbEvt), .usbIrq(usbIrq), .sharedIrqFlag(sharedIrqFlag), .controlOut(controlOut),
    .hostLogicReset(hostLogicReset), .resumeEop(resumeEop));
  uec_usb_far uec_usb_far_inst (.clk(clk), .flagsIn(flagsIn), .pulseIn(pulseIn), .usbEvt(usbEvt));
  // Pulses are counted so their exact edge does not matter
  always @(posedge clk) begin
    if (hostLogicReset === 1'b1) hostPulses++;
    if (resumeEop === 1'b1) eopPulses++;
  end
  task automatic complete_run;
    $display("Checks %0d, errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    checksDone++;
    if (g !== e) begin
      errTotal++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk32({31'h0, g}, {31'h0, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask
  // Live line bits are hidden by the mask where they would vary
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1;
    chk32(rdata & m, e);
  endtask
  task automatic flags(input logic [7:0] f);
    @(posedge clk);
    flagsIn <= f;
  endtask
  task automatic pulse(input logic [2:0] p);
    @(posedge clk);
    pulseIn <= p;
    @(posedge clk);
    pulseIn <= 3'h0;
    tick(2);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rdc(OFF_EVENT_ENABLE, 32'h0000_0000, 32'hFFFF_FFFF);
    rdc(OFF_MODULE_CONTROL, 32'h0000_0000, 32'h0000_003F);
    wr(OFF_EVENT_ENABLE, 32'hFFFF_FFFF);
    rdc(OFF_EVENT_ENABLE, 32'h0000_00FF, 32'hFFFF_FFFF);
    rdc(4'h2, 32'h0000_0000, 32'hFFFF_FFFF);
    for (int m = 0; m < 2; m++) begin
      wr(OFF_MODULE_CONTROL, m ? 32'h0000_0008 : 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
        flags(8'h01 << i);
        wr(OFF_EVENT_ENABLE, 32'h0000_0001 << i);
        tick(2);
        chk1(sharedIrqFlag, 1'b1);
        wr(OFF_EVENT_ENABLE, ~(32'h0000_0001 << i));
        tick(2);
        chk1(sharedIrqFlag, 1'b0);
      end
    end
    flags(8'h00);
    wr(OFF_MODULE_CONTROL, 32'h0000_0000);
    tick(2);
    chk1(usbIrq, 1'b0);
    rdc(OFF_EVENT_STATUS, 32'h0000_00FF, 32'hFFFF_FFFF);
    wr(OFF_EVENT_ENABLE, 32'h0000_000C);
    wr(OFF_STATUS_MASK, 32'h0000_0008);
    flags(8'h0E);
    flags(8'h00);
    tick(3);
    chk1(usbIrq, 1'b1);
    rdc(OFF_EVENT_STATUS, 32'h0000_000C, 32'hFFFF_FFFF);
    tick(2);
    chk1(usbIrq, 1'b0);
    flags(8'h04);
    flags(8'h00);
    tick(3);
    chk1(usbIrq, 1'b0);
    rdc(OFF_EVENT_STATUS, 32'h0000_0004, 32'hFFFF_FFFF);
    rdc(OFF_STATUS_MASK, 32'h0000_0008, 32'hFFFF_FFFF);
    pulse(3'b100);
    rdc(OFF_MODULE_CONTROL, 32'h0000_0020, 32'h0000_003F);
    chk32({24'h00_0000, controlOut & 8'h3F}, 32'h0000_0020);
    wr(OFF_MODULE_CONTROL, 32'h0000_0000);
    rdc(OFF_MODULE_CONTROL, 32'h0000_0000, 32'h0000_003F);
    wr(OFF_MODULE_CONTROL, 32'h0000_0008);
    pulse(3'b010);
    rdc(OFF_MODULE_CONTROL, 32'h0000_0028, 32'h0000_003F);
    wr(OFF_MODULE_CONTROL, 32'h0000_0008);
    rdc(OFF_MODULE_CONTROL, 32'h0000_0028, 32'h0000_003F);
    pulse(3'b001);
    rdc(OFF_MODULE_CONTROL, 32'h0000_0008, 32'h0000_003F);
    wr(OFF_MODULE_CONTROL, 32'h0000_000C);
    wr(OFF_MODULE_CONTROL, 32'h0000_0008);
    wr(OFF_MODULE_CONTROL, 32'h0000_0000);
    tick(3);
    chk32(32'(hostPulses), 32'h0000_0004);
    chk32(32'(eopPulses), 32'h0000_0001);
    complete_run();
  end
endmodule
